/* rtl/scr_pkg.sv */
package scr_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;
    localparam int PC_W = 10;
    localparam int NUM_CORES = 6;
    localparam logic [ADDR_W-1:0] ADDR_PLL = 10'h1a7;
    localparam logic [ADDR_W-1:0] ADDR_BACKUP = 10'h1a8;
    localparam logic [ADDR_W-1:0] ADDR_SPI = 10'h1a9;
    localparam logic [ADDR_W-1:0] ADDR_TR_BEGIN = 10'h1aa;
    localparam logic [ADDR_W-1:0] ADDR_TR_END = 10'h1ab;
    localparam logic [ADDR_W-1:0] ADDR_TR_SETUP = 10'h1ac;
    localparam logic [ADDR_W-1:0] ADDR_LOCK = 10'h1ad;
    localparam logic [ADDR_W-1:0] ADDR_UNLOCK = 10'h1af;
    localparam logic [DATA_W-1:0] UNLOCK_KEY = 16'h1337;
    localparam logic [1:0] PLL_RESET = 2'h1;
    localparam logic [7:0] SPI_RESET = 8'h0a;
    localparam int WD_W = 5;
    localparam int WD_SHIFT = 15;
    localparam int WD_CNT_W = WD_W + WD_SHIFT + 1;
    localparam int PLL_MULT_LO = 12;
    localparam int PLL_MULT_HI = 24;
    localparam logic [7:0] POST_ENDLESS = 8'hff;
    localparam int BK_RET = 1;
    localparam int BK_HOST_EN = 2;
    localparam int BK_CORE_LSB = 3;
    localparam int BK_DRV_OFF = 14;
    localparam int SPI_ERR_EN = 5;
    localparam int SPI_MODE = 6;
    localparam int SPI_FAST = 7;
    localparam int TR_RUN = 15;
    typedef enum logic [1:0] {SCR_W_SYNC, SCR_W_PC} scr_kind_t;
    typedef struct packed {
        scr_kind_t kind;
        logic [PC_W-1:0] value;
    } scr_trace_word_t;
    typedef enum {SCR_IDLE, SCR_SYNC, SCR_TRACE, SCR_POST} scr_trace_state_t;
endpackage

/* rtl/scr_fifo.sv */
`timescale 1ns/1ps
module scr_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("depth must be a power of two");
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wp_q;
    logic [AW:0] rp_q;
    logic push;
    logic pop;
    assign in_ready_o = (wp_q - rp_q) != (AW+1)'(DEPTH);
    assign out_valid_o = wp_q != rp_q;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_q[rp_q[AW-1:0]];
    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem_q[wp_q[AW-1:0]] <= in_data_i;
        end
    end
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (push) wp_q <= wp_q + 1'b1;
            if (pop) rp_q <= rp_q + 1'b1;
        end
    end
endmodule

/* rtl/scr_regs.sv */
`timescale 1ns/1ps
module scr_regs #(
    parameter logic [scr_pkg::PC_W-1:0] SYNC_CODE = 10'h2aa,
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic spi_reset_i,
    // register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [scr_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [scr_pkg::DATA_W-1:0] reg_wdata_i,
    output logic [scr_pkg::DATA_W-1:0] reg_rdata_o,
    // clock manager
    input wire logic ref_missing_i,
    input wire logic cksys_missing_i,
    input wire logic clk_mgr_to_internal_i,
    input wire logic clk_mgr_to_external_i,
    input wire logic monitor_tick_i,
    output logic pll_mult_hi_o,
    output logic [4:0] pll_mult_o,
    output logic pll_spread_en_o,
    output logic return_to_external_ref_o,
    output logic host_clock_irq_o,
    output logic [scr_pkg::NUM_CORES-1:0] core_clock_irq_o,
    output logic clk_ok_gate_o,
    // serial interface control
    input wire logic spi_error_i,
    input wire logic burst_gap_i,
    output logic miso_fast_o,
    output logic burst_mode_b_o,
    output logic spi_error_irq_o,
    output logic burst_timeout_o,
    // trace
    input wire logic [scr_pkg::NUM_CORES-1:0][scr_pkg::PC_W-1:0] core_program_counter_i,
    output logic trace_valid_o,
    input wire logic trace_ready_i,
    output scr_pkg::scr_trace_word_t trace_word_o,
    // locks
    output logic dev_lock_o,
    output logic [2:0] data_ram_tail_lock_o
);
    import scr_pkg::*;
    initial begin
        if (FIFO_DEPTH < 2) $error("fifo depth too small");
    end
    function automatic logic hit(input logic [ADDR_W-1:0] a);
        hit = reg_wr_i && reg_addr_i == a;
    endfunction
    logic [1:0] pll_q;
    logic pll_mult_q;
    logic lost_q;
    logic ret_q;
    logic ret_pulse_q;
    logic host_en_q;
    logic drv_off_q;
    logic [NUM_CORES-1:0] core_en_q;
    logic host_irq_q;
    logic [NUM_CORES-1:0] core_irq_q;
    logic [7:0] spi_q;
    logic [WD_CNT_W-1:0] wd_cnt_q;
    logic [PC_W-1:0] begin_q;
    logic [PC_W-1:0] end_q;
    logic run_q;
    logic [2:0] sel_q;
    logic [7:0] post_len_q;
    logic [7:0] post_cnt_q;
    logic dev_lock_q;
    logic [2:0] ram_lock_q;
    scr_trace_state_t st_q;
    logic clk_evt;
    logic ret_rise;
    logic unlock;
    logic bk_read;
    logic trace_done;
    logic [PC_W-1:0] pc_sel;
    logic push_valid;
    logic push_ready;
    scr_trace_word_t push_word;
    logic [WD_CNT_W-1:0] wd_limit;

    assign unlock = hit(ADDR_UNLOCK) && reg_wdata_i == UNLOCK_KEY;
    assign bk_read = reg_rd_i && reg_addr_i == ADDR_BACKUP;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pll_q <= PLL_RESET;
        end else if (spi_reset_i) begin
            pll_q <= PLL_RESET;
        end else if (hit(ADDR_PLL) && !dev_lock_q) begin
            pll_q <= reg_wdata_i[1:0];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pll_mult_q <= PLL_RESET[0];
        end else if (monitor_tick_i) begin
            pll_mult_q <= pll_q[0];
        end
    end
    assign pll_mult_hi_o = pll_mult_q;
    assign pll_mult_o = pll_mult_q ? 5'(PLL_MULT_HI) : 5'(PLL_MULT_LO);
    assign pll_spread_en_o = !pll_q[1];

    assign ret_rise = hit(ADDR_BACKUP) && reg_wdata_i[BK_RET] && !ret_q && lost_q;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ret_q <= 1'b0;
            ret_pulse_q <= 1'b0;
        end else if (spi_reset_i) begin
            ret_q <= 1'b0;
            ret_pulse_q <= 1'b0;
        end else begin
            ret_pulse_q <= ret_rise;
            if (ret_rise) ret_q <= 1'b1;
            else if (clk_mgr_to_external_i) ret_q <= 1'b0;
        end
    end
    assign return_to_external_ref_o = ret_pulse_q;

    // latched lost flag; set wins over clear
    // cleared only by a completed return or a serial reset
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lost_q <= 1'b0;
        end else if (spi_reset_i) begin
            lost_q <= 1'b0;
        end else if (ref_missing_i) begin
            lost_q <= 1'b1;
        end else if (ret_q && clk_mgr_to_external_i) begin
            lost_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            host_en_q <= 1'b0;
            core_en_q <= '0;
            drv_off_q <= 1'b0;
        end else if (spi_reset_i) begin
            host_en_q <= 1'b0;
            core_en_q <= '0;
            drv_off_q <= 1'b0;
        end else if (hit(ADDR_BACKUP) && !dev_lock_q) begin
            host_en_q <= reg_wdata_i[BK_HOST_EN];
            core_en_q <= reg_wdata_i[BK_CORE_LSB +: NUM_CORES];
            drv_off_q <= reg_wdata_i[BK_DRV_OFF];
        end
    end

    assign clk_evt = clk_mgr_to_internal_i || ret_pulse_q;
    // held until status read; a new event wins
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            host_irq_q <= 1'b0;
        end else if (spi_reset_i) begin
            host_irq_q <= 1'b0;
        end else if (clk_evt && host_en_q) begin
            host_irq_q <= 1'b1;
        end else if (bk_read) begin
            host_irq_q <= 1'b0;
        end
    end
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            core_irq_q <= '0;
        end else begin
            core_irq_q <= clk_evt ? core_en_q : '0;
        end
    end
    assign host_clock_irq_o = host_irq_q;
    assign core_clock_irq_o = core_irq_q;
    assign clk_ok_gate_o = !(drv_off_q && cksys_missing_i);

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            spi_q <= SPI_RESET;
        end else if (spi_reset_i) begin
            spi_q <= SPI_RESET;
        end else if (hit(ADDR_SPI) && !dev_lock_q) begin
            spi_q <= reg_wdata_i[7:0];
        end
    end
    assign miso_fast_o = spi_q[SPI_FAST];
    // burst format; the host keeps the change transfer valid in both modes
    assign burst_mode_b_o = spi_q[SPI_MODE];
    assign spi_error_irq_o = spi_q[SPI_ERR_EN] && spi_error_i;

    assign wd_limit = WD_CNT_W'({1'b0, spi_q[WD_W-1:0]} + 6'd1) << WD_SHIFT;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wd_cnt_q <= '0;
        end else if (!burst_gap_i || burst_mode_b_o) begin
            wd_cnt_q <= '0;
        end else if (wd_cnt_q != wd_limit) begin
            wd_cnt_q <= wd_cnt_q + 1'b1;
        end
    end
    assign burst_timeout_o = wd_cnt_q == wd_limit;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dev_lock_q <= 1'b0;
            ram_lock_q <= '0;
        end else if (spi_reset_i || unlock) begin
            dev_lock_q <= 1'b0;
            ram_lock_q <= '0;
        end else if (hit(ADDR_LOCK)) begin
            dev_lock_q <= dev_lock_q || reg_wdata_i[0];
            ram_lock_q <= ram_lock_q | reg_wdata_i[3:1];
        end
    end
    assign dev_lock_o = dev_lock_q;
    assign data_ram_tail_lock_o = ram_lock_q;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            begin_q <= '0;
            end_q <= '0;
            sel_q <= '0;
            post_len_q <= '0;
        end else if (spi_reset_i) begin
            begin_q <= '0;
            end_q <= '0;
            sel_q <= '0;
            post_len_q <= '0;
        end else begin
            if (hit(ADDR_TR_BEGIN)) begin_q <= reg_wdata_i[PC_W-1:0];
            if (hit(ADDR_TR_END)) end_q <= reg_wdata_i[PC_W-1:0];
            if (hit(ADDR_TR_SETUP)) begin
                sel_q <= reg_wdata_i[10:8];
                post_len_q <= reg_wdata_i[7:0];
            end
        end
    end

    // run bit; a write in the finishing cycle wins
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_q <= 1'b0;
        end else if (spi_reset_i) begin
            run_q <= 1'b0;
        end else if (hit(ADDR_TR_SETUP)) begin
            run_q <= reg_wdata_i[TR_RUN];
        end else if (trace_done) begin
            run_q <= 1'b0;
        end
    end

    // core select; unused codes fall back to the first core
    assign pc_sel = (sel_q < 3'(NUM_CORES)) ? core_program_counter_i[sel_q]
                                            : core_program_counter_i[0];
    assign trace_done = st_q == SCR_POST && post_len_q != POST_ENDLESS
                        && post_cnt_q == '0;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= SCR_IDLE;
            post_cnt_q <= '0;
        end else if (!run_q || spi_reset_i) begin
            st_q <= SCR_IDLE;
        end else begin
            case (st_q)
                SCR_IDLE: begin
                    if (pc_sel == begin_q) st_q <= SCR_SYNC;
                end
                SCR_SYNC: begin
                    if (push_ready) st_q <= SCR_TRACE;
                end
                SCR_TRACE: begin
                    if (push_ready && pc_sel == end_q) begin
                        st_q <= SCR_POST;
                        post_cnt_q <= post_len_q;
                    end
                end
                // post length; a full buffer stalls the count
                SCR_POST: begin
                    if (trace_done) st_q <= SCR_IDLE;
                    else if (push_ready && post_len_q != POST_ENDLESS) begin
                        post_cnt_q <= post_cnt_q - 1'b1;
                    end
                end
                default: st_q <= SCR_IDLE;
            endcase
        end
    end

    // stopping drops words not yet pushed; the buffer still drains what it holds
    assign push_valid = run_q && (st_q == SCR_SYNC || st_q == SCR_TRACE
                        || (st_q == SCR_POST && !trace_done));
    assign push_word.kind = (st_q == SCR_SYNC) ? SCR_W_SYNC : SCR_W_PC;
    assign push_word.value = (st_q == SCR_SYNC) ? SYNC_CODE : pc_sel;

    scr_fifo #(.WIDTH($bits(scr_trace_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(push_valid),
        .in_ready_o(push_ready),
        .in_data_i(push_word),
        .out_valid_o(trace_valid_o),
        .out_ready_i(trace_ready_i),
        .out_data_o(trace_word_o)
    );

    // read mux; registered data, unmapped reads zero
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            if (reg_addr_i == ADDR_PLL) reg_rdata_o <= {14'h0000, pll_q};
            else if (reg_addr_i == ADDR_BACKUP) begin
                reg_rdata_o <= {1'b0, drv_off_q, 5'h00, core_en_q, host_en_q, ret_q, lost_q};
            end else if (reg_addr_i == ADDR_SPI) reg_rdata_o <= {8'h00, spi_q};
            else if (reg_addr_i == ADDR_TR_BEGIN) reg_rdata_o <= {6'h00, begin_q};
            else if (reg_addr_i == ADDR_TR_END) reg_rdata_o <= {6'h00, end_q};
            else if (reg_addr_i == ADDR_TR_SETUP) begin
                reg_rdata_o <= {run_q, 4'h0, sel_q, post_len_q};
            end else if (reg_addr_i == ADDR_LOCK) reg_rdata_o <= {12'h000, ram_lock_q, dev_lock_q};
            else reg_rdata_o <= '0;
        end
    end

    sequence s_return_done;
        ret_q && clk_mgr_to_external_i && !ref_missing_i;
    endsequence
    sequence s_trace_start;
        st_q == SCR_IDLE && run_q && pc_sel == begin_q && !hit(ADDR_TR_SETUP);
    endsequence

    a_pll_on_tick: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $changed(pll_mult_o) |-> $past(monitor_tick_i)) else $error("pll changed off tick");
    a_mult_value: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        pll_mult_o == (pll_mult_hi_o ? 5'd24 : 5'd12)) else $error("bad multiplier");
    a_lost_latch: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ref_missing_i && !spi_reset_i |=> lost_q [*2] or (##1 $past(spi_reset_i)))
        else $error("lost flag not latched");
    a_lost_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $fell(lost_q) |-> $past(spi_reset_i) || $past(ret_q && clk_mgr_to_external_i))
        else $error("lost flag cleared without return");
    a_ret_return: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_return_done ##1 !spi_reset_i |-> !ret_q && !lost_q) else $error("return not done");
    a_host_irq: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        clk_mgr_to_internal_i && host_en_q && !spi_reset_i |=> host_clock_irq_o until bk_read)
        else $error("host request dropped");
    a_core_route: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        clk_mgr_to_internal_i |=> core_clock_irq_o == $past(core_en_q)) else $error("core route");
    a_drv_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        drv_off_q && cksys_missing_i |-> !clk_ok_gate_o) else $error("drivers not gated");
    a_lock_holds: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        dev_lock_q && !unlock && !spi_reset_i |=> dev_lock_q && $stable(pll_q) && $stable(spi_q))
        else $error("locked bits changed");
    a_unlock_key: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        unlock |=> !dev_lock_q && ram_lock_q == 3'h0) else $error("unlock failed");
    a_trace_sync: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_trace_start ##1 run_q |-> st_q == SCR_SYNC && push_word.value == SYNC_CODE)
        else $error("sync not emitted");
    a_trace_stop: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !run_q |=> !push_valid) else $error("trace not stopped");
endmodule

/* tb/scr_trace_sink.sv */
`timescale 1ns/1ps
module scr_trace_sink (
    // clock
    input wire logic ref_clk_i,
    // trace stream in
    input wire logic trace_valid_i,
    input wire scr_pkg::scr_trace_word_t trace_word_i,
    output logic trace_ready_o,
    // bench control
    input wire logic stall_i
);
    import scr_pkg::*;
    scr_trace_word_t got[$];
    // far side may stall at will, so the buffer can be seen to fill
    assign trace_ready_o = !stall_i;
    always @(posedge ref_clk_i) begin
        if (trace_valid_i && trace_ready_o) begin
            got.push_back(trace_word_i);
        end
    end
endmodule

/* tb/scr_regs_tb_top.sv */
`timescale 1ns/1ps
module scr_regs_tb_top;
    import scr_pkg::*;
    logic ref_clk_i = 0, rst_n_i = 0, spi_reset_i = 0, reg_wr_i = 0, reg_rd_i = 0;
    logic ref_missing_i = 0, cksys_missing_i = 0, clk_mgr_to_internal_i = 0;
    logic clk_mgr_to_external_i = 0, monitor_tick_i = 0, spi_error_i = 0, burst_gap_i = 0;
    logic trace_ready_i, stall = 0, pll_mult_hi_o, pll_spread_en_o, return_to_external_ref_o;
    logic host_clock_irq_o, clk_ok_gate_o, miso_fast_o, burst_mode_b_o, spi_error_irq_o;
    logic burst_timeout_o, trace_valid_o, dev_lock_o;
    logic [9:0] reg_addr_i = 0;
    logic [15:0] reg_wdata_i = 0, reg_rdata_o;
    logic [4:0] pll_mult_o;
    logic [5:0] core_clock_irq_o, core_seen = 0;
    logic [2:0] data_ram_tail_lock_o;
    logic [NUM_CORES-1:0][PC_W-1:0] pc = '0;
    scr_trace_word_t trace_word_o;
    int mismatches = 0, checks_done = 0, ret_cnt = 0;
    scr_regs #(.SYNC_CODE(10'h2aa)) uut (.ref_clk_i, .rst_n_i, .spi_reset_i, .reg_wr_i,
        .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .ref_missing_i, .cksys_missing_i,
        .clk_mgr_to_internal_i, .clk_mgr_to_external_i, .monitor_tick_i, .pll_mult_hi_o,
        .pll_mult_o, .pll_spread_en_o, .return_to_external_ref_o, .host_clock_irq_o,
        .core_clock_irq_o, .clk_ok_gate_o, .spi_error_i, .burst_gap_i, .miso_fast_o,
        .burst_mode_b_o, .spi_error_irq_o, .burst_timeout_o, .core_program_counter_i(pc),
        .trace_valid_o, .trace_ready_i, .trace_word_o, .dev_lock_o, .data_ram_tail_lock_o);
    scr_trace_sink sink (.ref_clk_i, .trace_valid_i(trace_valid_o),
        .trace_word_i(trace_word_o), .trace_ready_o(trace_ready_i), .stall_i(stall));
    initial begin
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    // pulses are short, so they are caught at the edge rather than polled
    always @(posedge ref_clk_i) begin
        ret_cnt <= ret_cnt + int'(return_to_external_ref_o);
        core_seen <= core_seen | core_clock_irq_o;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(negedge ref_clk_i);
        reg_wr_i = 1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge ref_clk_i);
        reg_wr_i = 0;
    endtask
    task automatic rd(input logic [9:0] a, output logic [15:0] d);
        @(negedge ref_clk_i);
        reg_rd_i = 1;
        reg_addr_i = a;
        @(negedge ref_clk_i);
        reg_rd_i = 0;
        d = reg_rdata_o;
    endtask
    task automatic rdchk(input logic [9:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        chk(d, exp, "register read");
    endtask
    initial begin
        repeat (60000) @(posedge ref_clk_i);
        mismatches++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        stop_test();
    end
    initial begin
        logic [15:0] d;
        int e, n;
        repeat (4) @(negedge ref_clk_i);
        rst_n_i = 1;
        rdchk(ADDR_PLL, 16'h0001); // pll default
        rdchk(ADDR_SPI, 16'h000a); // watchdog default
        for (int a = 'h1aa; a <= 'h1b0; a++) rdchk(10'(a), 16'h0000); // zero default
        chk(16'(pll_mult_o), 16'd24, "mult"); // times 24
        chk(16'(clk_ok_gate_o), 16'h0001, "gate"); // idle gate
        wr(ADDR_PLL, 16'h0002); // select 12
        chk(16'(pll_mult_hi_o), 16'h0001, "mult early"); // waits tick
        @(negedge ref_clk_i) monitor_tick_i = 1;
        @(negedge ref_clk_i) monitor_tick_i = 0;
        chk(16'(pll_mult_o), 16'd12, "mult"); // times 12
        chk(16'(pll_spread_en_o), 16'h0000, "spread"); // spread off
        @(negedge ref_clk_i) spi_reset_i = 1;
        @(negedge ref_clk_i) spi_reset_i = 0;
        rdchk(ADDR_PLL, 16'h0001); // serial reset
        $display("test pll done");
        wr(ADDR_SPI, 16'h00e0); // single whole write
        chk(16'({miso_fast_o, burst_mode_b_o}), 16'h0003, "spi bits"); // set
        @(negedge ref_clk_i) spi_error_i = 1;
        #1 chk(16'(spi_error_irq_o), 16'h0001, "err irq"); // enabled
        wr(ADDR_SPI, 16'h0000); // back to first mode
        chk(16'({miso_fast_o, burst_mode_b_o}), 16'h0000, "spi bits"); // clear
        chk(16'(spi_error_irq_o), 16'h0000, "err irq"); // masked
        spi_error_i = 0;
        burst_gap_i = 1;
        repeat (32700) @(negedge ref_clk_i);
        chk(16'(burst_timeout_o), 16'h0000, "gap early"); // one slot
        repeat (200) @(negedge ref_clk_i);
        chk(16'(burst_timeout_o), 16'h0001, "gap limit"); // one slot
        burst_gap_i = 0;
        $display("test serial done");
        wr(ADDR_BACKUP, 16'h0002); // no loss
        rdchk(ADDR_BACKUP, 16'h0000); // never set
        chk(16'(ret_cnt), 16'h0000, "no return"); // no effect
        @(negedge ref_clk_i) ref_missing_i = 1;
        @(negedge ref_clk_i) ref_missing_i = 0;
        wr(ADDR_BACKUP, 16'h40ac);
        rdchk(ADDR_BACKUP, 16'h40ad); // flag latched
        @(negedge ref_clk_i) clk_mgr_to_internal_i = 1;
        cksys_missing_i = 1;
        @(negedge ref_clk_i) clk_mgr_to_internal_i = 0;
        @(negedge ref_clk_i);
        chk(16'(host_clock_irq_o), 16'h0001, "host irq"); // raised
        chk(16'(core_seen), 16'h0015, "core irq"); // per core
        chk(16'(clk_ok_gate_o), 16'h0000, "gate"); // drivers off
        rdchk(ADDR_BACKUP, 16'h40ad); // read clears
        @(negedge ref_clk_i) core_seen = 0;
        chk(16'(host_clock_irq_o), 16'h0000, "host irq"); // cleared
        wr(ADDR_BACKUP, 16'h40ae); // rising edge
        // the retry request sets one edge after the pulse; a status read would clear it
        @(negedge ref_clk_i);
        chk(16'(host_clock_irq_o), 16'h0001, "retry irq"); // retry event
        rdchk(ADDR_BACKUP, 16'h40af); // pending
        chk(16'(ret_cnt), 16'h0001, "return"); // one request
        chk(16'(core_seen), 16'h0015, "retry core"); // retry event
        @(negedge ref_clk_i) clk_mgr_to_external_i = 1;
        @(negedge ref_clk_i) clk_mgr_to_external_i = 0;
        cksys_missing_i = 0;
        rdchk(ADDR_BACKUP, 16'h40ac); // flag cleared
        chk(16'(clk_ok_gate_o), 16'h0001, "gate"); // clock back
        $display("test clock done");
        wr(ADDR_LOCK, 16'h000f);
        chk(16'({data_ram_tail_lock_o, dev_lock_o}), 16'h000f, "locks"); // set
        wr(ADDR_SPI, 16'h00ff);
        rdchk(ADDR_SPI, 16'h0000); // write ignored
        wr(ADDR_LOCK, 16'h0000);
        rdchk(ADDR_LOCK, 16'h000f); // set only
        wr(ADDR_TR_END, 16'h0008);
        rdchk(ADDR_TR_END, 16'h0008); // unlocked reg
        wr(ADDR_UNLOCK, 16'h1336);
        chk(16'(dev_lock_o), 16'h0001, "bad key"); // wrong key
        wr(ADDR_UNLOCK, UNLOCK_KEY);
        rdchk(ADDR_LOCK, 16'h0000); // key clears
        wr(ADDR_TR_BEGIN, 16'h0005);
        $display("test lock done");
        for (int s = 0; s < 6; s++) begin
            pc = {NUM_CORES{10'h005}};
            pc[s] = 10'h000;
            sink.got.delete();
            wr(ADDR_TR_SETUP, 16'h8002 | 16'(s << 8)); // start
            repeat (4) @(negedge ref_clk_i);
            chk(16'(sink.got.size()), 16'h0000, "select"); // only chosen core
            for (int v = 5; v < 10; v++) begin
                pc[s] = 10'(v);
                repeat (2) @(negedge ref_clk_i);
            end
            e = 0;
            do begin
                rd(ADDR_TR_SETUP, d);
                e++;
            end while (d[TR_RUN] && e < 40);
            chk(d, 16'h0002 | 16'(s << 8), "run clear"); // self clear
            chk(16'(sink.got[0]), 16'h02aa, "sync"); // sync first
            e = -1;
            for (int i = sink.got.size() - 1; i >= 0; i--) if (sink.got[i] == 12'h408) e = i;
            chk(16'(sink.got.size() - e), 16'd3, "post len"); // two after stop
        end
        pc = '0;
        wr(ADDR_TR_SETUP, 16'h80ff);
        for (int v = 5; v < 10; v++) @(negedge ref_clk_i) pc[0] = 10'(v);
        repeat (30) @(negedge ref_clk_i);
        rdchk(ADDR_TR_SETUP, 16'h80ff); // endless
        stall = 1;
        repeat (20) @(negedge ref_clk_i);
        n = sink.got.size();
        chk(16'(trace_valid_o), 16'h0001, "full"); // words held while stalled
        wr(ADDR_TR_SETUP, 16'h0000); // stop at once
        stall = 0;
        repeat (20) @(negedge ref_clk_i);
        chk(16'(sink.got.size() - n), 16'd8, "drained"); // nothing after stop
        chk(16'(trace_valid_o), 16'h0000, "empty"); // stopped
        $display("test trace done");
        stop_test();
    end
endmodule
